/* File: include/port_pkg.sv */
package port_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices (byte address on the bus is four times the index)
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_PORT0 = 16'hff00;
    localparam logic [15:0] IDX_PORT1 = 16'hff01;
    localparam logic [15:0] IDX_PORT2 = 16'hff02;
    localparam logic [15:0] IDX_PORT13 = 16'hff0d;
    localparam logic [15:0] IDX_DIR0 = 16'hff20;
    localparam logic [15:0] IDX_DIR1 = 16'hff21;
    localparam logic [15:0] IDX_PU0 = 16'hff30;
    localparam logic [15:0] IDX_PU1 = 16'hff31;
    localparam logic [15:0] IDX_PINSEL = 16'hff40;
    localparam logic [15:0] IDX_ISC = 16'hff4f;

    localparam logic [ADDR_W-1:0] ADDR_PORT0 = {IDX_PORT0, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PORT1 = {IDX_PORT1, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PORT2 = {IDX_PORT2, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PORT13 = {IDX_PORT13, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DIR0 = {IDX_DIR0, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DIR1 = {IDX_DIR1, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PU0 = {IDX_PU0, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PU1 = {IDX_PU1, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PINSEL = {IDX_PINSEL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ISC = {IDX_ISC, 2'b00};

    ////////////////////////////////////////////////////////////////////////////////
    // Widths, reset values, field positions
    localparam int P0_BIDIR = 2;
    localparam int P1_BIDIR = 6;
    localparam int P2_WIDTH = 4;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam int PSEL_TIMER_H1 = 0;
    localparam int PSEL_MANCH = 1;
    localparam int PSEL_IRQ1 = 2;
    localparam int PSEL_IRQ3 = 3;
    localparam int ISC_IRQ0 = 0;
    localparam int ISC_CAPTURE = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin carriers
    typedef struct packed {
        logic dir;      // 1 = input
        logic latch;
        logic pu_sel;
        logic alt_or;   // Alternate output that needs latch 0
        logic alt_and;  // Alternate output that needs latch 1
    } pin_ctl_t;

    typedef struct packed {
        logic oe;
        logic out;
        logic pull;
        logic level;    // Level seen inside the chip
        logic rd;       // Value a data register read returns
    } pin_obs_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage : port_pkg

/* File: design/port_pin_cell.sv */
`timescale 1ns/10ps
module port_pin_cell
    import port_pkg::*;
(
    // Control from the register file
    input wire pin_ctl_t ctl,
    // Pad input
    input wire logic pad_in,
    // Observed pin state
    output pin_obs_t obs
);

    wire logic drive;
    wire logic value;

    assign drive = ~ctl.dir;
    // Latch 1 passes active-low style alternates, latch 0 passes active-high ones
    assign value = (ctl.latch & ctl.alt_and) | ctl.alt_or;
    assign obs.oe = drive;
    assign obs.out = value;
    // Alternate outputs also need direction 0, so input mode alone gates the pull-up
    assign obs.pull = ctl.dir & ctl.pu_sel;
    // Driven level is seen internally, so toggling an output reaches its interrupt tap
    assign obs.level = drive ? value : pad_in;
    assign obs.rd = ctl.dir ? pad_in : ctl.latch;

endmodule : port_pin_cell

/* File: design/mcu_port_block.sv */
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
module mcu_port_block
    import port_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] ADDRESS,
    input wire logic [3:0] BYTEENABLE,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // Oscillator option: internal high-speed clock chosen
    input wire logic OSC_INTERNAL_SEL,
    // Port 0 pads
    input wire logic [2:0] P0_IN,
    output logic [P0_BIDIR-1:0] P0_OUT,
    output logic [P0_BIDIR-1:0] P0_OE,
    output logic [P0_BIDIR-1:0] P0_PULLUP,
    // Port 1 pads
    input wire logic [P1_BIDIR-1:0] P1_IN,
    output logic [P1_BIDIR-1:0] P1_OUT,
    output logic [P1_BIDIR-1:0] P1_OE,
    output logic [P1_BIDIR-1:0] P1_PULLUP,
    // Port 2 and port 13 pads
    input wire logic [P2_WIDTH-1:0] P2_IN,
    output logic P13_OUT,
    // Alternate outputs from peripherals
    input wire logic MANCHESTER_OUT,
    input wire logic TIMER_H0_OUT,
    input wire logic TIMER_H1_OUT,
    input wire logic TIMER00_OUT,
    input wire logic SERIAL_CLOCK_OUT,
    input wire logic SERIAL_DATA_OUT,
    input wire logic UART_TRANSMIT,
    // Alternate inputs to peripherals
    output logic EXT_IRQ_ZERO,
    output logic EXT_IRQ_ONE,
    output logic EXT_IRQ_TWO,
    output logic EXT_IRQ_THREE,
    output logic TIMER00_CAPTURE_IN,
    output logic TIMER00_SECOND_IN,
    output logic SERIAL_CLOCK_PIN,
    output logic SERIAL_DATA_IN,
    output logic UART_RECEIVE
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    bus_state_t state_q;
    logic [31:0] rdata_q;
    logic [P0_BIDIR-1:0] dir0_q;
    logic [P1_BIDIR-1:0] dir1_q;
    logic [P0_BIDIR-1:0] lat0_q;
    logic [P1_BIDIR-1:0] lat1_q;
    logic lat13_q;
    logic [P0_BIDIR-1:0] pu0_q;
    logic [P1_BIDIR-1:0] pu1_q;
    logic [3:0] psel_q;
    logic [1:0] isc_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode: one wait state, answer on the second cycle of every request
    wire logic req;
    wire logic first;
    wire logic wr_go;
    wire logic lane0;
    wire logic [7:0] wbyte;
    wire logic hit_p0, hit_p1, hit_p2, hit_p13, hit_d0, hit_d1;
    wire logic hit_u0, hit_u1, hit_ps, hit_is;

    assign req = READ | WRITE;
    assign first = req & (state_q == BUS_IDLE);
    assign WAITREQUEST = first;
    assign READDATA = rdata_q;
    assign lane0 = BYTEENABLE[0];
    assign wbyte = WRITEDATA[7:0];
    // Writes take effect at the edge where waitrequest is low
    assign wr_go = WRITE & (state_q == BUS_ACK) & lane0;
    assign hit_p0 = ADDRESS == ADDR_PORT0;
    assign hit_p1 = ADDRESS == ADDR_PORT1;
    assign hit_p2 = ADDRESS == ADDR_PORT2;
    assign hit_p13 = ADDRESS == ADDR_PORT13;
    assign hit_d0 = ADDRESS == ADDR_DIR0;
    assign hit_d1 = ADDRESS == ADDR_DIR1;
    assign hit_u0 = ADDRESS == ADDR_PU0;
    assign hit_u1 = ADDRESS == ADDR_PU1;
    assign hit_ps = ADDRESS == ADDR_PINSEL;
    assign hit_is = ADDRESS == ADDR_ISC;

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            state_q <= BUS_IDLE;
        end else begin
            case (state_q)
                BUS_IDLE: state_q <= req ? BUS_ACK : BUS_IDLE;
                BUS_ACK: state_q <= BUS_IDLE;
                default: state_q <= BUS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file; a bit operation arrives as a full byte write
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            dir0_q <= DIR_RESET[P0_BIDIR-1:0];
            dir1_q <= DIR_RESET[P1_BIDIR-1:0];
            lat0_q <= LATCH_RESET[P0_BIDIR-1:0];
            lat1_q <= LATCH_RESET[P1_BIDIR-1:0];
            lat13_q <= LATCH_RESET[0];
            pu0_q <= SEL_RESET[P0_BIDIR-1:0];
            pu1_q <= SEL_RESET[P1_BIDIR-1:0];
            psel_q <= SEL_RESET[3:0];
            isc_q <= SEL_RESET[1:0];
        end else if (wr_go) begin
            // Latches load whatever the direction, so input-mode bits keep the byte too
            if (hit_p0) lat0_q <= wbyte[P0_BIDIR-1:0];
            if (hit_p1) lat1_q <= wbyte[P1_BIDIR-1:0];
            if (hit_p13) lat13_q <= wbyte[0];
            if (hit_d0) dir0_q <= wbyte[P0_BIDIR-1:0];
            if (hit_d1) dir1_q <= wbyte[P1_BIDIR-1:0];
            if (hit_u0) pu0_q <= wbyte[P0_BIDIR-1:0];
            if (hit_u1) pu1_q <= wbyte[P1_BIDIR-1:0];
            if (hit_ps) psel_q <= wbyte[3:0];
            if (hit_is) isc_q <= wbyte[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alternate output routing onto the pins
    wire logic h1_on_p13;
    wire logic mc_on_p13;
    wire logic [P0_BIDIR-1:0] or0;
    wire logic [P1_BIDIR-1:0] or1;
    wire logic [P1_BIDIR-1:0] and1;

    assign h1_on_p13 = psel_q[PSEL_TIMER_H1];
    assign mc_on_p13 = psel_q[PSEL_MANCH];
    assign or0[0] = MANCHESTER_OUT & ~mc_on_p13;
    assign or0[1] = TIMER00_OUT;
    assign or1[0] = 1'b0;
    assign or1[1] = 1'b0;
    assign or1[2] = SERIAL_DATA_OUT | (TIMER_H1_OUT & ~h1_on_p13);
    assign or1[3] = (TIMER_H1_OUT & h1_on_p13) | (MANCHESTER_OUT & mc_on_p13);
    assign or1[4] = 1'b0;
    assign or1[5] = TIMER_H0_OUT;
    // Serial clock and transmit idle high, so they gate a latch held at one
    assign and1[0] = SERIAL_CLOCK_OUT;
    assign and1[1] = 1'b1;
    assign and1[2] = 1'b1;
    assign and1[3] = UART_TRANSMIT;
    assign and1[4] = 1'b1;
    assign and1[5] = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin cells
    pin_obs_t obs0 [P0_BIDIR];
    pin_obs_t obs1 [P1_BIDIR];
    logic [P0_BIDIR-1:0] lvl0, rd0;
    logic [P1_BIDIR-1:0] lvl1, rd1;

    genvar gi;
    generate
        for (gi = 0; gi < P0_BIDIR; gi++) begin : g_port0
            pin_ctl_t ctl;
            assign ctl = '{dir: dir0_q[gi], latch: lat0_q[gi], pu_sel: pu0_q[gi],
                           alt_or: or0[gi], alt_and: 1'b1};
            port_pin_cell u_cell (
                .ctl(ctl),
                .pad_in(P0_IN[gi]),
                .obs(obs0[gi])
            );
            assign P0_OUT[gi] = obs0[gi].out;
            assign P0_OE[gi] = obs0[gi].oe;
            assign P0_PULLUP[gi] = obs0[gi].pull;
            assign lvl0[gi] = obs0[gi].level;
            assign rd0[gi] = obs0[gi].rd;
        end
        for (gi = 0; gi < P1_BIDIR; gi++) begin : g_port1
            pin_ctl_t ctl;
            assign ctl = '{dir: dir1_q[gi], latch: lat1_q[gi], pu_sel: pu1_q[gi],
                           alt_or: or1[gi], alt_and: and1[gi]};
            port_pin_cell u_cell (
                .ctl(ctl),
                .pad_in(P1_IN[gi]),
                .obs(obs1[gi])
            );
            assign P1_OUT[gi] = obs1[gi].out;
            assign P1_OE[gi] = obs1[gi].oe;
            assign P1_PULLUP[gi] = obs1[gi].pull;
            assign lvl1[gi] = obs1[gi].level;
            assign rd1[gi] = obs1[gi].rd;
        end
    endgenerate

    // Latch drives the pin straight, so reset forces it low
    assign P13_OUT = lat13_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Alternate input routing; taps see driven levels too, see the pin cell
    assign EXT_IRQ_ZERO = isc_q[ISC_IRQ0] ? lvl1[4] : lvl0[0];
    assign TIMER00_CAPTURE_IN = isc_q[ISC_CAPTURE] ? lvl1[4] : lvl0[0];
    assign EXT_IRQ_ONE = psel_q[PSEL_IRQ1] ? lvl1[0] : lvl1[3];
    assign EXT_IRQ_TWO = lvl0[1];
    assign EXT_IRQ_THREE = psel_q[PSEL_IRQ3] ? lvl1[2] : lvl1[1];
    assign TIMER00_SECOND_IN = lvl0[1];
    assign SERIAL_CLOCK_PIN = lvl1[0];
    assign SERIAL_DATA_IN = lvl1[1];
    assign UART_RECEIVE = lvl1[4];

    ////////////////////////////////////////////////////////////////////////////////
    // Read path; captured in the wait cycle and held while the master samples
    wire logic shared_rd;
    wire logic [7:0] rbyte;

    // Resonator pin reads a fixed zero where the value is undefined
    assign shared_rd = OSC_INTERNAL_SEL & P0_IN[2];
    assign rbyte = hit_p0 ? {5'h00, shared_rd, rd0} :
                   hit_p1 ? {2'h0, rd1} :
                   hit_p2 ? {4'h0, P2_IN} :
                   hit_p13 ? {7'h00, lat13_q} :
                   hit_d0 ? {6'h3f, dir0_q} :
                   hit_d1 ? {2'h3, dir1_q} :
                   hit_u0 ? {6'h00, pu0_q} :
                   hit_u1 ? {2'h0, pu1_q} :
                   hit_ps ? {4'h0, psel_q} :
                   hit_is ? {6'h00, isc_q} : 8'h00;

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            rdata_q <= 32'h0000_0000;
        end else if (READ & first) begin
            rdata_q <= {24'h00_0000, rbyte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    bus_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        first |=> !WAITREQUEST && state_q == BUS_ACK)
        else $error("bus answer not one cycle after request");

    dir_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $past(!RESETN) |-> dir0_q == 2'b11 && dir1_q == 6'h3f)
        else $error("direction not all ones after reset");

    latch_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $past(!RESETN) |-> lat0_q == 2'b00 && lat1_q == 6'h00 && !P13_OUT)
        else $error("output latch not cleared by reset");

    p13_write_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        wr_go && hit_p13 |=> P13_OUT == $past(WRITEDATA[0]))
        else $error("single output pin missed its write");

    input_no_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (P1_OE & dir1_q) == 6'h00 && (P0_OE & dir0_q) == 2'b00)
        else $error("input-mode pin is driven");

    pullup_off_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (P1_PULLUP & ~dir1_q) == 6'h00 && (P0_PULLUP & ~dir0_q) == 2'b00)
        else $error("pull-up on an output pin");

    read_mode_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        READ && first && hit_p1 |=>
        READDATA[7:0] == {2'b00, $past((dir1_q & P1_IN) | (~dir1_q & lat1_q))})
        else $error("port read mixes pin and latch wrongly");

    resonator_read_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        READ && first && hit_p0 && !OSC_INTERNAL_SEL |=> READDATA[2] == 1'b0)
        else $error("resonator pin read as port input");

    analog_read_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        READ && first && hit_p2 |=> READDATA == {28'h000_0000, $past(P2_IN)})
        else $error("input-only port read wrong");

    irq_route_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        psel_q[PSEL_IRQ1] && dir1_q[0] |-> EXT_IRQ_ONE == P1_IN[0])
        else $error("rerouted interrupt not on serial clock pin");

endmodule : mcu_port_block

/* File: bench/pad_board.sv */
`timescale 1ns/10ps
module pad_board (
    // Clock
    input wire logic clk,
    // Bidirectional pins, port 1 above port 0
    input wire logic [7:0] oe,
    input wire logic [7:0] out,
    input wire logic [7:0] pull,
    // Board drive; bit 8 is the shared input
    input wire logic [8:0] ext_en,
    input wire logic [8:0] ext_val,
    output logic [8:0] level
);
    // A floating pin wanders so a stale value never passes for a real one
    logic flip_q = 1'b0;
    always_ff @(posedge clk) begin
        flip_q <= ~flip_q;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pull[i] | flip_q;
        end
        level[8] = ext_en[8] ? ext_val[8] : flip_q;
    end
endmodule : pad_board

/* File: bench/test_mcu_port_block.sv */
`timescale 1ns/10ps
module test_mcu_port_block
    import port_pkg::*;
;
    logic CLK_SYS = 1'b0;
    logic RESETN = 1'b0;
    logic [ADDR_W-1:0] ADDRESS = '0;
    logic [3:0] BYTEENABLE = 4'hf;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = '0;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    logic OSC_INTERNAL_SEL = 1'b1;
    logic [2:0] P0_IN;
    logic [1:0] P0_OUT, P0_OE, P0_PULLUP;
    logic [5:0] P1_IN, P1_OUT, P1_OE, P1_PULLUP;
    logic [3:0] P2_IN = 4'h0;
    logic P13_OUT;
    logic MANCHESTER_OUT = 1'b0, TIMER_H1_OUT = 1'b0;
    // Idle peripherals leave the latch in control
    logic TIMER_H0_OUT = 1'b0, TIMER00_OUT = 1'b0, SERIAL_DATA_OUT = 1'b0;
    logic SERIAL_CLOCK_OUT = 1'b1, UART_TRANSMIT = 1'b1;
    logic EXT_IRQ_ZERO, EXT_IRQ_ONE, EXT_IRQ_TWO, EXT_IRQ_THREE, TIMER00_CAPTURE_IN;
    logic TIMER00_SECOND_IN, SERIAL_CLOCK_PIN, SERIAL_DATA_IN, UART_RECEIVE;
    logic [8:0] ext_en = 9'h1ff, ext_val = 9'h000, level;
    int fails = 0, checks = 0;

    always #2 CLK_SYS = ~CLK_SYS;
    assign P0_IN = {level[8], level[1:0]};
    assign P1_IN = level[7:2];

    mcu_port_block i_dut (
        .CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDRESS(ADDRESS), .BYTEENABLE(BYTEENABLE),
        .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .OSC_INTERNAL_SEL(OSC_INTERNAL_SEL),
        .P0_IN(P0_IN), .P0_OUT(P0_OUT), .P0_OE(P0_OE), .P0_PULLUP(P0_PULLUP),
        .P1_IN(P1_IN), .P1_OUT(P1_OUT), .P1_OE(P1_OE), .P1_PULLUP(P1_PULLUP),
        .P2_IN(P2_IN), .P13_OUT(P13_OUT), .MANCHESTER_OUT(MANCHESTER_OUT),
        .TIMER_H0_OUT(TIMER_H0_OUT), .TIMER_H1_OUT(TIMER_H1_OUT), .TIMER00_OUT(TIMER00_OUT),
        .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
        .UART_TRANSMIT(UART_TRANSMIT), .EXT_IRQ_ZERO(EXT_IRQ_ZERO), .EXT_IRQ_ONE(EXT_IRQ_ONE),
        .EXT_IRQ_TWO(EXT_IRQ_TWO), .EXT_IRQ_THREE(EXT_IRQ_THREE),
        .TIMER00_CAPTURE_IN(TIMER00_CAPTURE_IN), .TIMER00_SECOND_IN(TIMER00_SECOND_IN),
        .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_DATA_IN(SERIAL_DATA_IN),
        .UART_RECEIVE(UART_RECEIVE)
    );
    pad_board i_board (
        .clk(CLK_SYS), .oe({P1_OE, P0_OE}), .out({P1_OUT, P0_OUT}),
        .pull({P1_PULLUP, P0_PULLUP}), .ext_en(ext_en), .ext_val(ext_val), .level(level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // Request held until waitrequest is seen low; an idle edge keeps drivers apart
    task automatic bus(input logic w, input logic [3:0] be, input logic [15:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        ADDRESS <= {idx, 2'b00};
        BYTEENABLE <= be;
        WRITEDATA <= {24'h00_0000, wd};
        READ <= ~w;
        WRITE <= w;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (WAITREQUEST !== 1'b0 && n < 64);
        if (n >= 64) fails++;
        rd = READDATA[7:0];
        READ <= 1'b0;
        WRITE <= 1'b0;
        @(posedge CLK_SYS);
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, 4'hf, idx, wd, d);
    endtask : wr

    task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        bus(1'b0, 4'hf, idx, 8'h00, d);
        check(d, exp);
    endtask : rchk

    // Pins are combinational; idle edges keep checks clear of bus traffic
    task automatic settle();
        repeat (3) @(posedge CLK_SYS);
    endtask : settle

    function automatic logic [7:0] pin_rd(input logic [7:0] dir, lat, pad);
        return (dir & pad) | (~dir & lat);
    endfunction : pin_rd

    task automatic do_reset();
        RESETN <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        check(P13_OUT, 1'b0);
        check({P1_OE, P0_OE, P1_PULLUP, P0_PULLUP}, 16'h0000);
        @(posedge CLK_SYS);
        RESETN <= 1'b1;
    endtask : do_reset

    task automatic rst_chk();
        ext_en <= 9'h1ff;
        ext_val <= 9'($urandom);
        rchk(IDX_DIR0, 8'hff);
        rchk(IDX_DIR1, 8'hff);
        rchk(IDX_PORT13, 8'h00);
        rchk(IDX_PINSEL, 8'h00);
        rchk(IDX_PORT1, {2'h0, ext_val[7:2]});
        ext_en <= 9'h100;
        wr(IDX_DIR0, 8'hfc);
        wr(IDX_DIR1, 8'hc0);
        rchk(IDX_PORT0, {5'h00, OSC_INTERNAL_SEL & ext_val[8], 2'h0});
        rchk(IDX_PORT1, 8'h00);
    endtask : rst_chk

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] dir, lat, pu, en, rnd, ex, ps, is, d;
        void'($urandom(74003));
        do_reset();
        rst_chk();
        for (int k = 0; k < 24; k++) begin
            dir = 8'($urandom);
            lat = 8'($urandom);
            pu = 8'($urandom);
            rnd = 8'($urandom);
            en = dir & (~pu | rnd);
            ext_en <= {1'b1, en};
            ext_val <= 9'($urandom);
            OSC_INTERNAL_SEL <= 1'($urandom);
            P2_IN <= 4'($urandom);
            wr(IDX_DIR0, {6'h3f, dir[1:0]});
            wr(IDX_DIR1, {2'h3, dir[7:2]});
            wr(IDX_PU0, {6'h00, pu[1:0]});
            wr(IDX_PU1, {2'h0, pu[7:2]});
            wr(IDX_PORT0, {6'h3f, lat[1:0]});
            wr(IDX_PORT1, {2'h3, lat[7:2]});
            wr(IDX_PORT2, 8'($urandom));
            wr(IDX_PORT13, lat);
            settle();
            ex = pin_rd(dir, lat, (ext_val[7:0] & en) | ~en);
            check({P1_OE, P0_OE}, {24'h00_0000, ~dir});
            check({P1_OUT, P0_OUT} & ~dir, lat & ~dir);
            check({P1_PULLUP, P0_PULLUP}, dir & pu);
            check(P13_OUT, lat[0]);
            rchk(IDX_PORT0, {5'h00, OSC_INTERNAL_SEL & ext_val[8], ex[1:0]});
            rchk(IDX_PORT1, {2'h0, ex[7:2]});
            rchk(IDX_PORT2, {4'h0, P2_IN});
            rchk(IDX_PORT13, {7'h00, lat[0]});
        end
        wr(IDX_DIR0, 8'hff);
        wr(IDX_DIR1, 8'hff);
        ext_en <= 9'h1ff;
        wr(IDX_PORT0, 8'h02);
        wr(IDX_PORT1, 8'h2a);
        settle();
        check({P1_OE, P0_OE}, 8'h00);
        rchk(IDX_PORT1, {2'h0, ext_val[7:2]});
        ext_en <= 9'h100;
        wr(IDX_DIR0, 8'hfc);
        wr(IDX_DIR1, 8'hc0);
        check({P1_OUT, P0_OUT}, 8'haa);
        bus(1'b1, 4'h0, IDX_PORT1, 8'h15, d);
        rchk(IDX_PORT1, 8'h2a);
        rchk(16'hff10, 8'h00);
        for (int k = 0; k < 16; k++) begin
            ps = 8'(k);
            is = 8'($urandom) & 8'h03;
            wr(IDX_DIR0, 8'hff);
            wr(IDX_DIR1, 8'hff);
            ext_en <= 9'h1ff;
            ext_val <= 9'($urandom);
            wr(IDX_PINSEL, ps);
            wr(IDX_ISC, is);
            settle();
            check(EXT_IRQ_ZERO, is[0] ? ext_val[6] : ext_val[0]);
            check(TIMER00_CAPTURE_IN, is[1] ? ext_val[6] : ext_val[0]);
            check(EXT_IRQ_ONE, ps[2] ? ext_val[2] : ext_val[5]);
            check(EXT_IRQ_THREE, ps[3] ? ext_val[4] : ext_val[3]);
            check({UART_RECEIVE, SERIAL_DATA_IN, SERIAL_CLOCK_PIN, TIMER00_SECOND_IN},
                  {ext_val[6], ext_val[3:1]});
            ext_en <= 9'h100;
            wr(IDX_PORT0, 8'h00);
            wr(IDX_PORT1, 8'h00);
            wr(IDX_DIR0, 8'hfc);
            wr(IDX_DIR1, 8'hc0);
            TIMER_H1_OUT <= 1'b1;
            settle();
            check(P1_OUT[3:2], {ps[0], ~ps[0]});
            TIMER_H1_OUT <= 1'b0;
            MANCHESTER_OUT <= 1'b1;
            settle();
            check({P1_OUT[3], P0_OUT[0]}, {ps[1], ~ps[1]});
            MANCHESTER_OUT <= 1'b0;
            wr(IDX_PORT0, 8'h02);
            check(EXT_IRQ_TWO, 1'b1);
            // Latch 1 under the AND-type alternates, 0 under the OR-type ones
            wr(IDX_PORT1, 8'h09);
            {SERIAL_CLOCK_OUT, UART_TRANSMIT} <= 2'(k);
            {TIMER_H0_OUT, SERIAL_DATA_OUT} <= 2'(k >> 2);
            settle();
            check({P1_OUT[5], P1_OUT[3:2], P1_OUT[0]}, {k[3], k[0], k[2], k[1]});
            {SERIAL_CLOCK_OUT, UART_TRANSMIT, TIMER_H0_OUT, SERIAL_DATA_OUT} <= 4'b1100;
        end
        wr(IDX_PORT13, 8'h01);
        check(P13_OUT, 1'b1);
        do_reset();
        rst_chk();
        summarize();
    end

    initial begin
        repeat (40000) @(posedge CLK_SYS);
        fails++;
        summarize();
    end
endmodule : test_mcu_port_block
